// ---- hdl/uch_cfg.svh ----
`ifndef UCH_CFG_SVH
`define UCH_CFG_SVH
// register byte offsets
`define UCH_OFS_MODE 8'h00
`define UCH_OFS_STAT 8'h04
`define UCH_OFS_CMD  8'h08
`define UCH_OFS_DATA 8'h0C
`define UCH_OFS_PHI  8'h10
`define UCH_OFS_PLO  8'h14
`define UCH_OFS_ISR  8'h18
`define UCH_OFS_IMR  8'h1C
// reset values
`define UCH_MODE_RST 8'h00
`define UCH_PRE_RST  8'h00
`define UCH_IMR_RST  8'h00
// command codes in the upper nibble
`define UCH_CMD_RST_ERR 4'h4
`define UCH_CMD_BRK_ON  4'h6
`define UCH_CMD_BRK_OFF 4'h7
`define UCH_CMD_TMO_ON  4'hA
`define UCH_CMD_TMO_OFF 4'hC
// mode register fields
`define UCH_MB_RXINT  6
`define UCH_MB_ERRBLK 5
`define UCH_MB_PTYPE  2
`define UCH_PAR_WITH  2'b00
`define UCH_PAR_NONE  2'b10
`define UCH_PAR_WAKE  2'b11
// interrupt status bits
`define UCH_ISR_TMR 3
// 16x tick counts and FIFO full level
`define UCH_START_SMP 4'h7
`define UCH_HALF_BIT  4'h7
`define UCH_BIT_LAST  4'hF
`define UCH_FIFO_FULL 2'd3
`endif

// ---- hdl/uch_pkg.sv ----
package uch_pkg;
	typedef enum logic [3:0] {
		TX_IDLE  = 4'b0001,
		TX_START = 4'b0010,
		TX_SHIFT = 4'b0100,
		TX_STOP  = 4'b1000
	} uch_tx_state_t;
	typedef enum logic [5:0] {
		RX_IDLE  = 6'b000001,
		RX_START = 6'b000010,
		RX_SHIFT = 6'b000100,
		RX_STOP  = 6'b001000,
		RX_FEW   = 6'b010000,
		RX_BRKW  = 6'b100000
	} uch_rx_state_t;
endpackage

// ---- hdl/uch_channel.sv ----
// Notes on behaviour
// RULE1 - idle line high, empty flag set
// RULE2 - holding write clears empty, resyncs clock
// RULE3 - break command holds line low
// RULE4 - disabled transmitter finishes pending characters
// RULE5 - no holding loads while transmitter disabled
// RULE6 - start edge rechecked mid-bit, else discarded
// RULE7 - sample bit centres, LSB first
// RULE8 - character into FIFO, upper bits zero
// RULE9 - errors stored with character first
// RULE10 - framing low half bit means start
// RULE11 - break loads one zero character, flag
// RULE12 - after break wait two high bit edges
// RULE13 - command AX enables, CX cancels time-out
// RULE14 - FIFO load reloads timer; expiry sets status
// RULE15 - software presets timer beyond one character
// RULE16 - three deep FIFO, ready and full flags
// RULE17 - mode bit six selects receive interrupt
// RULE18 - holding read returns oldest, then pops
// RULE19 - per-character errors, block mode accumulates
// RULE20 - status read leaves FIFO alone
// RULE21 - full FIFO: overrun at next start
// RULE22 - wake mode sends address/data bit
// RULE23 - disabled wake receiver keeps address only
`include "uch_cfg.svh"
`timescale 1ns/100ps
module uch_channel #(
	parameter int BAUD_DIV = 16
) (
	input  wire logic        clk_sys,
	input  wire logic        rst,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic             pready,
	output logic [31:0]      prdata,
	output logic             pslverr,
	input  wire logic        rxd,
	output logic             txd,
	output logic             irq
);
	localparam logic [15:0] DIV_LAST = 16'(BAUD_DIV - 1);

	// character helpers
	function automatic logic [7:0] chr_mask(input logic [7:0] d, input logic [1:0] len);
		chr_mask = d & (8'hFF >> (2'd3 - len));
	endfunction
	function automatic logic par_bit(input logic [7:0] d, input logic [7:0] m);
		if (m[4:3] == `UCH_PAR_WITH)
			par_bit = (^chr_mask(d, m[1:0])) ^ m[`UCH_MB_PTYPE];
		else
			par_bit = m[`UCH_MB_PTYPE];
	endfunction
	function automatic logic [3:0] frame_bits(input logic [7:0] m);
		frame_bits = 4'd5 + {2'b00, m[1:0]} + {3'b000, m[4:3] != `UCH_PAR_NONE};
	endfunction
	function automatic logic [8:0] tx_frame(input logic [7:0] d, input logic [7:0] m);
		tx_frame = {1'b0, chr_mask(d, m[1:0])}
			| ({8'h00, par_bit(d, m)} << (4'd5 + {2'b00, m[1:0]}));
	endfunction

	uch_pkg::uch_tx_state_t tx_state_reg;
	uch_pkg::uch_rx_state_t rx_state_reg;
	logic [7:0]  mode_reg_one, timer_preset_high, timer_preset_low, interrupt_mask_reg;
	logic        rx_en_reg, tx_en_reg, brk_reg, tmo_en_reg;
	logic [7:0]  tx_holding_reg;
	logic        tx_hold_full_reg;
	logic [8:0]  tx_sh_reg, rx_sh_reg;
	logic [3:0]  tx_sub_reg, tx_bit_reg, rx_sub_reg, rx_bit_reg;
	logic [15:0] tx_div_reg, rx_div_reg, tmr_cnt_reg;
	logic        rx_s1_reg, rx_s2_reg, rx_s3_reg, rx_q_reg, rx_prev_reg;
	logic        rx_done_reg;
	logic [10:0] rx_word_reg, pend_reg;
	logic        pend_valid_reg;
	logic [10:0] rx_holding_fifo [3];
	logic [1:0]  fifo_cnt_reg;
	logic [2:0]  err_acc_reg;
	logic        ovr_reg, tmr_run_reg, isr_tmr_reg;
	logic        pready_reg, pslverr_reg, txd_reg, irq_reg;
	logic [31:0] prdata_reg;

	// bus strobes and shared events
	logic wr_acc, rd_acc, thr_wr, cmd_wr, pop, push, rst_err;
	logic tx_tick, rx_tick, start_ok, wake;
	logic [3:0]  code;
	logic [3:0]  isr_val;
	logic [7:0]  channel_status_reg;
	logic [2:0]  err_view;
	assign wr_acc   = psel & penable & pready_reg & pwrite;
	assign rd_acc   = psel & penable & pready_reg & ~pwrite;
	assign cmd_wr   = wr_acc && paddr == `UCH_OFS_CMD;
	assign code     = pwdata[7:4];
	assign rst_err  = cmd_wr && code == `UCH_CMD_RST_ERR;
	assign tx_tick  = tx_div_reg == DIV_LAST;
	assign rx_tick  = rx_div_reg == DIV_LAST;
	assign wake     = mode_reg_one[4:3] == `UCH_PAR_WAKE;
	// RULE5 loads only while enabled
	assign thr_wr = wr_acc && paddr == `UCH_OFS_DATA && tx_en_reg && !tx_hold_full_reg;
	// RULE18 pop on holding read completion
	assign pop  = rd_acc && paddr == `UCH_OFS_DATA && fifo_cnt_reg != 2'd0;
	// RULE21 shift register waits while full
	assign push = pend_valid_reg && (fifo_cnt_reg != `UCH_FIFO_FULL || pop);
	assign start_ok = rx_state_reg == uch_pkg::RX_START && rx_tick
		&& rx_sub_reg == `UCH_START_SMP && !rx_q_reg;

	// software configuration
	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
		begin
			mode_reg_one       <= `UCH_MODE_RST;
			timer_preset_high  <= `UCH_PRE_RST;
			timer_preset_low   <= `UCH_PRE_RST;
			interrupt_mask_reg <= `UCH_IMR_RST;
		end
		else if (wr_acc)
		begin
			case (paddr)
				`UCH_OFS_MODE: mode_reg_one <= pwdata[7:0];
				`UCH_OFS_PHI:  timer_preset_high <= pwdata[7:0];
				`UCH_OFS_PLO:  timer_preset_low <= pwdata[7:0];
				`UCH_OFS_IMR:  interrupt_mask_reg <= pwdata[7:0];
				default:       mode_reg_one <= mode_reg_one;
			endcase
		end
	end

	// command decode: enables, break, time-out
	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
		begin
			rx_en_reg  <= 1'b0;
			tx_en_reg  <= 1'b0;
			brk_reg    <= 1'b0;
			tmo_en_reg <= 1'b0;
		end
		else if (cmd_wr)
		begin
			if (pwdata[0])
				rx_en_reg <= 1'b1;
			if (pwdata[1])
				rx_en_reg <= 1'b0;
			if (pwdata[2])
				tx_en_reg <= 1'b1;
			if (pwdata[3])
				tx_en_reg <= 1'b0;
			// RULE3 break start and stop
			if (code == `UCH_CMD_BRK_ON)
				brk_reg <= 1'b1;
			if (code == `UCH_CMD_BRK_OFF)
				brk_reg <= 1'b0;
			// RULE13 time-out mode on/off
			if (code == `UCH_CMD_TMO_ON)
				tmo_en_reg <= 1'b1;
			if (code == `UCH_CMD_TMO_OFF)
				tmo_en_reg <= 1'b0;
		end
	end

	// transmitter
	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
		begin
			tx_state_reg     <= uch_pkg::TX_IDLE;
			tx_holding_reg   <= 8'h00;
			tx_hold_full_reg <= 1'b0;
			tx_sh_reg        <= 9'h000;
			tx_sub_reg       <= 4'h0;
			tx_bit_reg       <= 4'h0;
			tx_div_reg       <= 16'h0000;
		end
		else
		begin
			// RULE2 restart bit clock on load while idle
			if (tx_tick || (thr_wr && tx_state_reg == uch_pkg::TX_IDLE))
				tx_div_reg <= 16'h0000;
			else
				tx_div_reg <= tx_div_reg + 16'h0001;
			if (thr_wr)
			begin
				tx_holding_reg   <= pwdata[7:0];
				tx_hold_full_reg <= 1'b1;
			end
			if (tx_tick)
				tx_sub_reg <= tx_sub_reg + 4'h1;
			case (tx_state_reg)
				uch_pkg::TX_IDLE:
					if (tx_hold_full_reg)
					begin
						tx_sh_reg        <= tx_frame(tx_holding_reg, mode_reg_one);
						tx_hold_full_reg <= 1'b0;
						tx_sub_reg       <= 4'h0;
						tx_state_reg     <= uch_pkg::TX_START;
					end
				uch_pkg::TX_START:
					if (tx_tick && tx_sub_reg == `UCH_BIT_LAST)
					begin
						tx_bit_reg   <= 4'h0;
						tx_state_reg <= uch_pkg::TX_SHIFT;
					end
				uch_pkg::TX_SHIFT:
					// RULE22 parity or address/data bit
					if (tx_tick && tx_sub_reg == `UCH_BIT_LAST)
					begin
						tx_sh_reg  <= tx_sh_reg >> 1;
						tx_bit_reg <= tx_bit_reg + 4'h1;
						if (tx_bit_reg == frame_bits(mode_reg_one) - 4'h1)
							tx_state_reg <= uch_pkg::TX_STOP;
					end
				uch_pkg::TX_STOP:
					if (tx_tick && tx_sub_reg == `UCH_BIT_LAST)
					begin
						// RULE4 pending character sent regardless
						if (tx_hold_full_reg)
						begin
							tx_sh_reg        <= tx_frame(tx_holding_reg, mode_reg_one);
							tx_hold_full_reg <= 1'b0;
							tx_state_reg     <= uch_pkg::TX_START;
						end
						else
							tx_state_reg <= uch_pkg::TX_IDLE;
					end
				default: tx_state_reg <= uch_pkg::TX_IDLE;
			endcase
		end
	end

	// serial output; RULE1 idle mark, RULE3 break low
	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
			txd_reg <= 1'b1;
		else if (brk_reg || tx_state_reg == uch_pkg::TX_START)
			txd_reg <= 1'b0;
		else if (tx_state_reg == uch_pkg::TX_SHIFT)
			txd_reg <= tx_sh_reg[0];
		else
			txd_reg <= 1'b1;
	end

	// input synchroniser, change taken when stages two and three agree
	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
		begin
			rx_s1_reg   <= 1'b1;
			rx_s2_reg   <= 1'b1;
			rx_s3_reg   <= 1'b1;
			rx_q_reg    <= 1'b1;
			rx_prev_reg <= 1'b1;
		end
		else
		begin
			rx_s1_reg   <= rxd;
			rx_s2_reg   <= rx_s1_reg;
			rx_s3_reg   <= rx_s2_reg;
			rx_prev_reg <= rx_q_reg;
			if (rx_s2_reg == rx_s3_reg)
				rx_q_reg <= rx_s3_reg;
		end
	end

	// receiver
	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
		begin
			rx_state_reg <= uch_pkg::RX_IDLE;
			rx_sh_reg    <= 9'h000;
			rx_sub_reg   <= 4'h0;
			rx_bit_reg   <= 4'h0;
			rx_div_reg   <= 16'h0000;
			rx_done_reg  <= 1'b0;
			rx_word_reg  <= 11'h000;
		end
		else
		begin
			rx_done_reg <= 1'b0;
			if (rx_tick || (rx_state_reg == uch_pkg::RX_IDLE && rx_prev_reg && !rx_q_reg))
				rx_div_reg <= 16'h0000;
			else
				rx_div_reg <= rx_div_reg + 16'h0001;
			if (rx_tick)
				rx_sub_reg <= rx_sub_reg + 4'h1;
			case (rx_state_reg)
				uch_pkg::RX_IDLE:
					if (rx_prev_reg && !rx_q_reg)
					begin
						rx_sub_reg   <= 4'h0;
						rx_sh_reg    <= 9'h000;
						rx_state_reg <= uch_pkg::RX_START;
					end
				uch_pkg::RX_START:
					// RULE6 recheck start bit at centre
					if (rx_tick && rx_sub_reg == `UCH_START_SMP)
					begin
						rx_sub_reg   <= 4'h0;
						rx_bit_reg   <= 4'h0;
						rx_sh_reg    <= 9'h000;
						rx_state_reg <= rx_q_reg ? uch_pkg::RX_IDLE : uch_pkg::RX_SHIFT;
					end
				uch_pkg::RX_SHIFT:
					// RULE7 one sample per bit centre
					if (rx_tick && rx_sub_reg == `UCH_BIT_LAST)
					begin
						rx_sh_reg[rx_bit_reg] <= rx_q_reg;
						rx_bit_reg            <= rx_bit_reg + 4'h1;
						if (rx_bit_reg == frame_bits(mode_reg_one) - 4'h1)
							rx_state_reg <= uch_pkg::RX_STOP;
					end
				uch_pkg::RX_STOP:
					if (rx_tick && rx_sub_reg == `UCH_BIT_LAST)
					begin
						// RULE8 masked data; RULE9 errors ride with it
						rx_word_reg[7:0] <= chr_mask(rx_sh_reg[7:0], mode_reg_one[1:0]);
						rx_word_reg[8] <= wake ? rx_sh_reg[4'd5 + {2'b00, mode_reg_one[1:0]}]
							: (mode_reg_one[4:3] != `UCH_PAR_NONE
							&& rx_sh_reg[4'd5 + {2'b00, mode_reg_one[1:0]}]
							!= par_bit(rx_sh_reg[7:0], mode_reg_one));
						rx_word_reg[9]  <= !rx_q_reg;
						// RULE11 all-zero frame is one break character
						rx_word_reg[10] <= !rx_q_reg && rx_sh_reg == 9'h000;
						// RULE23 disabled wake receiver keeps address only
						rx_done_reg <= rx_en_reg
							|| (wake && rx_sh_reg[4'd5 + {2'b00, mode_reg_one[1:0]}]);
						rx_sub_reg <= 4'h0;
						rx_bit_reg <= 4'h0;
						if (rx_q_reg)
							rx_state_reg <= uch_pkg::RX_IDLE;
						else if (rx_sh_reg == 9'h000)
							rx_state_reg <= uch_pkg::RX_BRKW;
						else
							rx_state_reg <= uch_pkg::RX_FEW;
					end
				uch_pkg::RX_FEW:
					// RULE10 still low half a bit on: new start
					if (rx_tick && rx_sub_reg == `UCH_HALF_BIT)
					begin
						rx_sub_reg   <= 4'h0;
						rx_state_reg <= rx_q_reg ? uch_pkg::RX_IDLE : uch_pkg::RX_START;
					end
				uch_pkg::RX_BRKW:
					// RULE12 two high samples on 1x edges
					if (rx_tick && rx_sub_reg == `UCH_BIT_LAST)
					begin
						rx_bit_reg <= rx_q_reg ? rx_bit_reg + 4'h1 : 4'h0;
						if (rx_q_reg && rx_bit_reg == 4'h1)
							rx_state_reg <= uch_pkg::RX_IDLE;
					end
				default: rx_state_reg <= uch_pkg::RX_IDLE;
			endcase
		end
	end

	// shift-register hold and three-deep FIFO
	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
		begin
			pend_reg       <= 11'h000;
			pend_valid_reg <= 1'b0;
			fifo_cnt_reg   <= 2'd0;
			for (int i = 0; i < 3; i++)
				rx_holding_fifo[i] <= 11'h000;
		end
		else
		begin
			// RULE21 a newer character replaces the waiting one
			if (rx_done_reg)
			begin
				pend_reg       <= rx_word_reg;
				pend_valid_reg <= 1'b1;
			end
			else if (push)
				pend_valid_reg <= 1'b0;
			// RULE18 oldest leaves after the read
			if (pop)
			begin
				rx_holding_fifo[0] <= rx_holding_fifo[1];
				rx_holding_fifo[1] <= rx_holding_fifo[2];
			end
			// RULE16 three positions
			if (push)
				rx_holding_fifo[pop ? fifo_cnt_reg - 2'd1 : fifo_cnt_reg] <= pend_reg;
			fifo_cnt_reg <= fifo_cnt_reg + {1'b0, push} - {1'b0, pop};
		end
	end

	// error accumulation and overrun; set wins over reset-error
	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
		begin
			err_acc_reg <= 3'b000;
			ovr_reg     <= 1'b0;
		end
		else
		begin
			// RULE19 OR of each new top character
			if (push && (fifo_cnt_reg == 2'd0 || (fifo_cnt_reg == 2'd1 && pop)))
				err_acc_reg <= (rst_err ? 3'b000 : err_acc_reg) | pend_reg[10:8];
			else if (pop && fifo_cnt_reg[1])
				err_acc_reg <= (rst_err ? 3'b000 : err_acc_reg) | rx_holding_fifo[1][10:8];
			else if (rst_err)
				err_acc_reg <= 3'b000;
			// RULE21 overrun flagged at the new start bit
			if (start_ok && pend_valid_reg)
				ovr_reg <= 1'b1;
			else if (rst_err)
				ovr_reg <= 1'b0;
		end
	end

	// time-out timer on 16x ticks
	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
		begin
			tmr_cnt_reg <= 16'h0000;
			tmr_run_reg <= 1'b0;
			isr_tmr_reg <= 1'b0;
		end
		else
		begin
			// RULE14 reload on each FIFO load, flag on expiry
			if (push && tmo_en_reg)
			begin
				tmr_cnt_reg <= {timer_preset_high, timer_preset_low};
				tmr_run_reg <= 1'b1;
			end
			else if (tmr_run_reg && rx_tick)
			begin
				tmr_cnt_reg <= tmr_cnt_reg - 16'h0001;
				if (tmr_cnt_reg == 16'h0000)
					tmr_run_reg <= 1'b0;
			end
			if (tmr_run_reg && rx_tick && tmr_cnt_reg == 16'h0000)
				isr_tmr_reg <= 1'b1;
			else if (wr_acc && paddr == `UCH_OFS_ISR && pwdata[`UCH_ISR_TMR])
				isr_tmr_reg <= 1'b0;
		end
	end

	// status views; RULE19 character or block mode
	assign err_view = mode_reg_one[`UCH_MB_ERRBLK] ? err_acc_reg
		: (fifo_cnt_reg != 2'd0 ? rx_holding_fifo[0][10:8] : 3'b000);
	assign channel_status_reg = {err_view, ovr_reg, tx_state_reg == uch_pkg::TX_IDLE
		&& !tx_hold_full_reg, tx_en_reg && !tx_hold_full_reg,
		fifo_cnt_reg == `UCH_FIFO_FULL, fifo_cnt_reg != 2'd0};
	// RULE17 receive interrupt source select
	assign isr_val = {isr_tmr_reg, 1'b0, mode_reg_one[`UCH_MB_RXINT]
		? channel_status_reg[1] : channel_status_reg[0], channel_status_reg[2]};

	// APB slave: answer prepared in setup, one access cycle
	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
		begin
			pready_reg  <= 1'b0;
			pslverr_reg <= 1'b0;
			prdata_reg  <= 32'h00000000;
			irq_reg     <= 1'b0;
		end
		else
		begin
			irq_reg     <= |(isr_val & interrupt_mask_reg[3:0]);
			pready_reg  <= psel && !penable;
			pslverr_reg <= psel && !penable && paddr > `UCH_OFS_IMR;
			// RULE20 status read has no side effect
			case (paddr)
				`UCH_OFS_MODE: prdata_reg <= {24'h000000, mode_reg_one};
				`UCH_OFS_STAT: prdata_reg <= {24'h000000, channel_status_reg};
				`UCH_OFS_DATA: prdata_reg <= {24'h000000, rx_holding_fifo[0][7:0]};
				`UCH_OFS_PHI:  prdata_reg <= {24'h000000, timer_preset_high};
				`UCH_OFS_PLO:  prdata_reg <= {24'h000000, timer_preset_low};
				`UCH_OFS_ISR:  prdata_reg <= {28'h0000000, isr_val};
				`UCH_OFS_IMR:  prdata_reg <= {24'h000000, interrupt_mask_reg};
				default:       prdata_reg <= 32'h00000000;
			endcase
		end
	end

	assign pready  = pready_reg;
	assign pslverr = pslverr_reg;
	assign prdata  = prdata_reg;
	assign txd     = txd_reg;
	assign irq     = irq_reg;

	property p_idle_high;
		@(posedge clk_sys) disable iff (rst)
		(tx_state_reg == uch_pkg::TX_IDLE && !tx_hold_full_reg && !brk_reg) |=> txd_reg;
	endproperty
	a_idle_high: assert property (p_idle_high) else $error("idle line not high"); // RULE1
	property p_load_clears;
		@(posedge clk_sys) disable iff (rst)
		thr_wr |=> !channel_status_reg[3] ##1 !channel_status_reg[3];
	endproperty
	a_load_clears: assert property (p_load_clears) else $error("empty flag stayed"); // RULE2
	property p_break_low;
		@(posedge clk_sys) disable iff (rst)
		brk_reg |=> !txd_reg;
	endproperty
	a_break_low: assert property (p_break_low) else $error("break not low"); // RULE3
	property p_no_load_dis;
		@(posedge clk_sys) disable iff (rst)
		(!tx_en_reg && !tx_hold_full_reg) |=> !tx_hold_full_reg;
	endproperty
	a_no_load_dis: assert property (p_no_load_dis) else $error("load while off"); // RULE5
	property p_false_start;
		@(posedge clk_sys) disable iff (rst)
		(rx_state_reg == uch_pkg::RX_START && rx_tick && rx_sub_reg == `UCH_START_SMP
		&& rx_q_reg) |=> rx_state_reg == uch_pkg::RX_IDLE;
	endproperty
	a_false_start: assert property (p_false_start) else $error("false start kept"); // RULE6
	property p_pop_count;
		@(posedge clk_sys) disable iff (rst)
		(pop && !push) |=> fifo_cnt_reg == $past(fifo_cnt_reg) - 2'd1;
	endproperty
	a_pop_count: assert property (p_pop_count) else $error("pop miscounted"); // RULE18
	property p_stat_read;
		@(posedge clk_sys) disable iff (rst)
		(rd_acc && paddr == `UCH_OFS_STAT && !push) |=> $stable(fifo_cnt_reg);
	endproperty
	a_stat_read: assert property (p_stat_read) else $error("status read moved FIFO"); // RULE20
	property p_full_hold;
		@(posedge clk_sys) disable iff (rst)
		(fifo_cnt_reg == `UCH_FIFO_FULL && !pop) |=> fifo_cnt_reg == `UCH_FIFO_FULL;
	endproperty
	a_full_hold: assert property (p_full_hold) else $error("full FIFO changed"); // RULE21
	property p_tmr_expire;
		@(posedge clk_sys) disable iff (rst)
		(tmr_run_reg && rx_tick && tmr_cnt_reg == 16'h0000 && !(push && tmo_en_reg))
		|=> isr_tmr_reg && !tmr_run_reg;
	endproperty
	a_tmr_expire: assert property (p_tmr_expire) else $error("timer flag missing"); // RULE14
endmodule // uch_channel

// ---- test/uch_remote.sv ----
`timescale 1ns/100ps
// far-end serial device: sends to rxd, listens on txd
module uch_remote #(
	parameter int BIT_CYC = 32
) (
	input  wire logic clk_sys,
	input  wire logic txd,
	output logic      rxd
);
	// line idles at mark
	initial rxd = 1'b1;

	task send(input logic [7:0] d, input int nb, input logic stp);
		rxd <= 1'b0;
		repeat (BIT_CYC) @(posedge clk_sys);
		for (int i = 0; i < nb; i++)
		begin
			rxd <= d[i];
			repeat (BIT_CYC) @(posedge clk_sys);
		end
		rxd <= stp;
		repeat (BIT_CYC) @(posedge clk_sys);
		rxd <= 1'b1;
		repeat (BIT_CYC) @(posedge clk_sys);
	endtask

	task brk(input int nbits);
		rxd <= 1'b0;
		repeat (nbits * BIT_CYC) @(posedge clk_sys);
		rxd <= 1'b1;
		repeat (3 * BIT_CYC) @(posedge clk_sys);
	endtask

	// samples nb bits after the start bit at bit centres
	task get(output logic [8:0] d, input int nb);
		d = 9'h000;
		wait (txd === 1'b0);
		repeat (BIT_CYC / 2) @(posedge clk_sys);
		for (int i = 0; i < nb; i++)
		begin
			repeat (BIT_CYC) @(posedge clk_sys);
			d[i] = txd;
		end
	endtask
endmodule // uch_remote

// ---- test/uch_channel_test.sv ----
`timescale 1ns/100ps
module uch_channel_test;
	localparam int DIV = 2;
	localparam int BIT = 16 * DIV;
	logic        clk_sys = 1'b0;
	logic        rst     = 1'b1;
	logic        psel    = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite  = 1'b0;
	logic [7:0]  paddr   = 8'h00;
	logic [31:0] pwdata  = 32'h0;
	logic        pready;
	logic [31:0] prdata;
	logic        pslverr;
	logic        rxd;
	logic        txd;
	logic        irq;
	logic [31:0] q;
	logic [8:0]  c;
	logic        serr;
	int          n_errors  = 0;
	int          cmp_count = 0;

	uch_channel #(.BAUD_DIV(DIV)) dut_u (.clk_sys(clk_sys), .rst(rst), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.pready(pready), .prdata(prdata), .pslverr(pslverr), .rxd(rxd), .txd(txd),
		.irq(irq));
	uch_remote #(.BIT_CYC(BIT)) rem_u (.clk_sys(clk_sys), .txd(txd), .rxd(rxd));

	// 200 MHz clock
	always #2.5 clk_sys = ~clk_sys;

	// one apb transfer, held until pready
	task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= wr;
		paddr   <= a;
		pwdata  <= d;
		@(posedge clk_sys);
		penable <= 1'b1;
		do
		begin
			@(posedge clk_sys);
		end
		while (pready !== 1'b1);
		q    = prdata;
		serr = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		// idle edge so the next setup never reassigns in this step
		@(posedge clk_sys);
	endtask

	// compare and count
	task chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp)
		begin
			n_errors++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task close_out;
		$display("compares %0d mismatches %0d", cmp_count, n_errors);
		if (n_errors == 0 && cmp_count > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	// watchdog
	initial
	begin
		repeat (60000) @(posedge clk_sys);
		n_errors++;
		close_out();
	end

	// main sequence
	initial
	begin
		repeat (4) @(posedge clk_sys);
		rst <= 1'b0;
		@(posedge clk_sys);
		chk({31'h0, txd}, 32'h1);
		apb(1'b0, 8'h20, 32'h0);
		chk({31'h0, serr}, 32'h1);
		$display("test reset and map done");
		apb(1'b1, 8'h00, 32'h13);
		apb(1'b1, 8'h0C, 32'hA5);
		apb(1'b1, 8'h08, 32'h04);
		fork
			rem_u.get(c, 8);
			apb(1'b1, 8'h0C, 32'h3C);
		join
		chk({23'h0, c}, 32'h3C);
		repeat (2 * BIT) @(posedge clk_sys);
		apb(1'b0, 8'h04, 32'h0);
		chk(q & 32'h08, 32'h08);
		chk({31'h0, txd}, 32'h1);
		apb(1'b1, 8'h08, 32'h60);
		repeat (3 * BIT) @(posedge clk_sys);
		chk({31'h0, txd}, 32'h0);
		apb(1'b1, 8'h08, 32'h70);
		repeat (BIT) @(posedge clk_sys);
		chk({31'h0, txd}, 32'h1);
		$display("test transmit done");
		apb(1'b1, 8'h00, 32'h10);
		apb(1'b1, 8'h08, 32'h01);
		rem_u.send(8'hF1, 5, 1'b1);
		rem_u.send(8'h0A, 5, 1'b1);
		rem_u.send(8'h15, 5, 1'b1);
		apb(1'b0, 8'h04, 32'h0);
		chk(q & 32'h03, 32'h03);
		apb(1'b0, 8'h04, 32'h0);
		chk(q & 32'h03, 32'h03);
		rem_u.send(8'h01, 5, 1'b1);
		rem_u.send(8'h02, 5, 1'b1);
		apb(1'b0, 8'h04, 32'h0);
		chk(q & 32'h10, 32'h10);
		apb(1'b0, 8'h0C, 32'h0);
		chk(q, 32'h11);
		apb(1'b0, 8'h0C, 32'h0);
		chk(q, 32'h0A);
		apb(1'b0, 8'h0C, 32'h0);
		chk(q, 32'h15);
		$display("test receive fifo done");
		repeat (3)
			apb(1'b0, 8'h0C, 32'h0);
		apb(1'b1, 8'h08, 32'h40);
		rem_u.brk(12);
		apb(1'b0, 8'h04, 32'h0);
		chk(q & 32'h81, 32'h81);
		apb(1'b0, 8'h0C, 32'h0);
		chk(q, 32'h00);
		apb(1'b0, 8'h04, 32'h0);
		chk(q & 32'h01, 32'h00);
		$display("test break done");
		apb(1'b1, 8'h08, 32'h40);
		apb(1'b1, 8'h10, 32'h01);
		apb(1'b1, 8'h14, 32'h00);
		apb(1'b1, 8'h1C, 32'h08);
		apb(1'b1, 8'h08, 32'hA0);
		rem_u.send(8'h07, 5, 1'b1);
		apb(1'b0, 8'h18, 32'h0);
		chk(q & 32'h08, 32'h00);
		repeat (700) @(posedge clk_sys);
		apb(1'b0, 8'h18, 32'h0);
		chk(q & 32'h08, 32'h08);
		chk({31'h0, irq}, 32'h1);
		apb(1'b1, 8'h18, 32'h08);
		apb(1'b0, 8'h18, 32'h0);
		chk(q & 32'h08, 32'h00);
		apb(1'b1, 8'h08, 32'hC0);
		apb(1'b0, 8'h0C, 32'h0);
		chk(q, 32'h07);
		$display("test time-out done");
		// wake mode, block errors, full-flag interrupt, rx off
		apb(1'b1, 8'h00, 32'h7C);
		apb(1'b1, 8'h08, 32'h42);
		fork
			begin
				rem_u.get(c, 6);
				chk({23'h0, c}, 32'h33);
				rem_u.get(c, 6);
				chk({23'h0, c}, 32'h2C);
			end
			begin
				apb(1'b1, 8'h0C, 32'h13);
				apb(1'b1, 8'h0C, 32'h0C);
				apb(1'b1, 8'h08, 32'h08);
			end
		join
		apb(1'b1, 8'h0C, 32'h05);
		repeat (2 * BIT) @(posedge clk_sys);
		apb(1'b0, 8'h04, 32'h0);
		chk(q & 32'h0C, 32'h08);
		rem_u.send(8'h25, 6, 1'b1);
		rem_u.send(8'h0A, 6, 1'b1);
		apb(1'b0, 8'h04, 32'h0);
		chk(q & 32'h23, 32'h21);
		apb(1'b0, 8'h18, 32'h0);
		chk(q & 32'h02, 32'h00);
		apb(1'b0, 8'h0C, 32'h0);
		chk(q, 32'h05);
		apb(1'b0, 8'h04, 32'h0);
		chk(q & 32'h21, 32'h20);
		$display("test wake done");
		close_out();
	end
endmodule // uch_channel_test
